/* File: design/dit_pkg.sv */
// Package: register map, fields, reset values and codes for the dual interval timer block
package dit_pkg;
    // Register word offsets (Wishbone word index wb_adr_i[10:2] = offset)
    localparam logic [8:0] OFF_A_RUN = 9'h100;
    localparam logic [8:0] OFF_A_LCMP = 9'h102;
    localparam logic [8:0] OFF_A_UCMP = 9'h103;
    localparam logic [8:0] OFF_A_MODE = 9'h104;
    localparam logic [8:0] OFF_A_FLOP = 9'h105;
    localparam logic [8:0] OFF_B_RUN = 9'h108;
    localparam logic [8:0] OFF_B_LCMP = 9'h10A;
    localparam logic [8:0] OFF_B_UCMP = 9'h10B;
    localparam logic [8:0] OFF_B_MODE = 9'h10C;
    localparam logic [8:0] OFF_B_FLOP = 9'h10D;
    localparam logic [8:0] OFF_IRQ_STAT = 9'h110;
    localparam logic [8:0] OFF_IRQ_MASK = 9'h111;
    localparam logic [8:0] OFF_CTRL = 9'h112;
    // Run register fields
    localparam int RUN_LOWER = 0;
    localparam int RUN_UPPER = 1;
    localparam int RUN_PRESC = 2;
    localparam int RUN_SLEEP = 3;
    localparam int RUN_DBUF = 7;
    localparam logic [7:0] RUN_MASK = 8'h8F;
    // Mode register fields
    localparam int MODE_LCLK = 0;
    localparam int MODE_UCLK = 2;
    localparam int MODE_PWM = 4;
    localparam int MODE_OP = 6;
    // Flop control fields
    localparam int FLOP_SRC = 0;
    localparam int FLOP_EN = 1;
    localparam int FLOP_CMD = 2;
    localparam logic [7:0] FLOP_RESET = 8'h0C;
    localparam logic [7:0] FLOP_MASK = 8'h0F;
    localparam logic [1:0] CMD_TOGGLE = 2'h0;
    localparam logic [1:0] CMD_SET = 2'h1;
    localparam logic [1:0] CMD_CLEAR = 2'h2;
    localparam logic [1:0] CMD_KEEP = 2'h3;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] CMP_RESET = 8'h00;
    localparam logic [7:0] RUN_RESET = 8'h00;
    localparam logic [7:0] CNT_RESET = 8'h00;
    // Prescaler: 11-bit count, taps rise every 4 (fine), 16, 64 and 1024 clocks
    localparam int PRE_W = 11;
    localparam int TAP_FINE = 1;
    localparam int TAP_DIV4 = 3;
    localparam int TAP_DIV16 = 5;
    localparam int TAP_DIV256 = 9;
    // Interrupt status bits: pair A lower/upper, pair B lower/upper
    localparam int IRQ_W = 4;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

    typedef enum logic [1:0] {
        OP_TWO8 = 2'b00,
        OP_SIXTEEN = 2'b01,
        OP_PPG = 2'b10,
        OP_PWM = 2'b11
    } dit_op_e;
endpackage : dit_pkg

/* File: design/dit_timer_regs.sv */
// Dual 8-bit interval timer pairs with register file, output flops and interrupts
`timescale 1ns/1ps
module dit_timer_regs
    import dit_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [10:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic externalCountPin,
    input wire logic secondIdleMode,
    output logic flopOutputPinA,
    output logic flopOutputPinB,
    output logic irqOut
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic extMeta_q, extSync_q, extPrev_q, idleMeta_q, idleSync_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            extMeta_q <= 1'b0;
            extSync_q <= 1'b0;
            extPrev_q <= 1'b0;
            idleMeta_q <= 1'b0;
            idleSync_q <= 1'b0;
        end else begin
            extMeta_q <= externalCountPin;
            extSync_q <= extMeta_q;
            extPrev_q <= extSync_q;
            idleMeta_q <= secondIdleMode;
            idleSync_q <= idleMeta_q;
        end
    end
    wire extRise = extSync_q & ~extPrev_q;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire [8:0] regIdx = wb_adr_i[10:2];
    wire busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wrByte = busReq & wb_we_i & wb_sel_i[0];
    wire [7:0] wrData = wb_dat_i[7:0];

    logic [7:0] runA_q, runB_q, modeA_q, modeB_q, flopA_q, flopB_q;
    logic [7:0] lBufA_q, lBufB_q, lCmpA_q, lCmpB_q, uCmpA_q, uCmpB_q;
    logic [IRQ_W-1:0] irqStat_q, irqMask_q;
    logic [7:0] cntLA_q, cntUA_q, cntLB_q, cntUB_q;
    logic outA_q, outB_q;
    logic [PRE_W-1:0] preA_q, preB_q, preAPrev_q, preBPrev_q;

    wire wrRunA = wrByte && regIdx == OFF_A_RUN;
    wire wrRunB = wrByte && regIdx == OFF_B_RUN;
    wire wrModeA = wrByte && regIdx == OFF_A_MODE;
    wire wrModeB = wrByte && regIdx == OFF_B_MODE;
    wire wrFlopA = wrByte && regIdx == OFF_A_FLOP;
    wire wrFlopB = wrByte && regIdx == OFF_B_FLOP;
    wire wrLCmpA = wrByte && regIdx == OFF_A_LCMP;
    wire wrLCmpB = wrByte && regIdx == OFF_B_LCMP;
    wire wrUCmpA = wrByte && regIdx == OFF_A_UCMP;
    wire wrUCmpB = wrByte && regIdx == OFF_B_UCMP;
    wire wrStat = wrByte && regIdx == OFF_IRQ_STAT;
    wire wrMask = wrByte && regIdx == OFF_IRQ_MASK;

    // Compare registers read as zero: write-only
    wire [7:0] rdSel =
        (regIdx == OFF_A_RUN) ? (runA_q & RUN_MASK) :
        (regIdx == OFF_B_RUN) ? (runB_q & RUN_MASK) :
        (regIdx == OFF_A_MODE) ? modeA_q :
        (regIdx == OFF_B_MODE) ? modeB_q :
        (regIdx == OFF_A_FLOP) ? flopA_q :
        (regIdx == OFF_B_FLOP) ? flopB_q :
        (regIdx == OFF_IRQ_STAT) ? {4'h0, irqStat_q} :
        (regIdx == OFF_IRQ_MASK) ? {4'h0, irqMask_q} :
        (regIdx == OFF_CTRL) ? {6'h00, outB_q, outA_q} : 8'h00;

    // ------------------------------------------------------------
    // Clock selection and compare helpers
    // ------------------------------------------------------------
    function automatic logic tapRise(input logic [PRE_W-1:0] cur, input logic [PRE_W-1:0] prev, input int b);
        tapRise = cur[b] & ~prev[b];
    endfunction : tapRise

    // Zero compare fires on counter wrap, i.e. when the count is all ones
    function automatic logic isMatch(input logic [7:0] cnt, input logic [7:0] cmp, input logic tick);
        isMatch = tick && ((cmp == 8'h00) ? (cnt == 8'hFF) : (cnt + 8'h01 == cmp));
    endfunction : isMatch

    function automatic logic lowerTick(input logic [1:0] sel, input logic pin,
                                       input logic [PRE_W-1:0] cur, input logic [PRE_W-1:0] prev);
        unique case (sel)
            2'b00: lowerTick = pin;
            2'b01: lowerTick = tapRise(cur, prev, TAP_FINE);
            2'b10: lowerTick = tapRise(cur, prev, TAP_DIV4);
            2'b11: lowerTick = tapRise(cur, prev, TAP_DIV16);
        endcase
    endfunction : lowerTick

    function automatic logic upperTick(input logic [1:0] sel, input logic lmatch,
                                       input logic [PRE_W-1:0] cur, input logic [PRE_W-1:0] prev);
        unique case (sel)
            2'b00: upperTick = lmatch;
            2'b01: upperTick = tapRise(cur, prev, TAP_FINE);
            2'b10: upperTick = tapRise(cur, prev, TAP_DIV16);
            2'b11: upperTick = tapRise(cur, prev, TAP_DIV256);
        endcase
    endfunction : upperTick

    // Sleep gating: idle with keep-running clear freezes the pair
    wire actA = ~(idleSync_q & ~runA_q[RUN_SLEEP]);
    wire actB = ~(idleSync_q & ~runB_q[RUN_SLEEP]);

    wire opTwoA = modeA_q[MODE_OP+1:MODE_OP] == OP_TWO8;
    wire opTwoB = modeB_q[MODE_OP+1:MODE_OP] == OP_TWO8;

    // Second pair has no count pin; code 00 never ticks
    wire tickLA = actA & runA_q[RUN_LOWER] &
        lowerTick(modeA_q[MODE_LCLK+1:MODE_LCLK], extRise, preA_q, preAPrev_q);
    wire tickLB = actB & runB_q[RUN_LOWER] &
        lowerTick(modeB_q[MODE_LCLK+1:MODE_LCLK], 1'b0, preB_q, preBPrev_q);
    wire matchLA = isMatch(cntLA_q, lCmpA_q, tickLA);
    wire matchLB = isMatch(cntLB_q, lCmpB_q, tickLB);
    wire tickUA = actA & runA_q[RUN_UPPER] &
        upperTick(modeA_q[MODE_UCLK+1:MODE_UCLK], matchLA, preA_q, preAPrev_q);
    wire tickUB = actB & runB_q[RUN_UPPER] &
        upperTick(modeB_q[MODE_UCLK+1:MODE_UCLK], matchLB, preB_q, preBPrev_q);
    wire matchUA = isMatch(cntUA_q, uCmpA_q, tickUA);
    wire matchUB = isMatch(cntUB_q, uCmpB_q, tickUB);

    // Only the two-timer source choice is modelled; other modes use lower match
    wire selA = opTwoA ? (flopA_q[FLOP_SRC] ? matchUA : matchLA) : matchLA;
    wire selB = opTwoB ? (flopB_q[FLOP_SRC] ? matchUB : matchLB) : matchLB;
    wire togA = flopA_q[FLOP_EN] & selA;
    wire togB = flopB_q[FLOP_EN] & selB;

    function automatic logic nextOut(input logic cur, input logic wr, input logic [1:0] cmd, input logic tog);
        logic v;
        v = cur;
        if (wr) begin
            unique case (cmd)
                CMD_TOGGLE: v = ~cur;
                CMD_SET: v = 1'b1;
                CMD_CLEAR: v = 1'b0;
                CMD_KEEP: v = cur;
            endcase
        end
        nextOut = tog ? ~v : v;
    endfunction : nextOut

    // Stopped counters sit at zero; a match restarts the interval
    function automatic logic [7:0] nextCount(input logic run, input logic match, input logic [7:0] cnt,
                                             input logic tick);
        if (!run || match) begin
            nextCount = CNT_RESET;
        end else begin
            nextCount = cnt + {7'h00, tick};
        end
    endfunction : nextCount

    // Idle freezes the prescaler without clearing it, so its phase survives sleep
    function automatic logic [PRE_W-1:0] nextPre(input logic run, input logic act,
                                                 input logic [PRE_W-1:0] cur);
        if (!run) begin
            nextPre = '0;
        end else if (act) begin
            nextPre = cur + 1'b1;
        end else begin
            nextPre = cur;
        end
    endfunction : nextPre

    // Command field is a strobe; it always reads back as keep
    function automatic logic [7:0] flopStore(input logic [7:0] d);
        flopStore = (d & FLOP_MASK) | {4'h0, CMD_KEEP, 2'b00};
    endfunction : flopStore

    wire [IRQ_W-1:0] irqEvt = {matchUB, matchLB, matchUA, matchLA};
    // Set wins over write-one-to-clear
    wire [IRQ_W-1:0] irqStatD = (irqStat_q & ~(wrStat ? wrData[IRQ_W-1:0] : 4'h0)) | irqEvt;

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    // Registered ack costs one wait state but keeps the read mux off the master's path
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= busReq;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_dat_o <= UNMAPPED_DATA;
        end else begin
            wb_dat_o <= {24'h000000, rdSel};
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            runA_q <= RUN_RESET;
        end else if (wrRunA) begin
            runA_q <= wrData & RUN_MASK;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            runB_q <= RUN_RESET;
        end else if (wrRunB) begin
            runB_q <= wrData & RUN_MASK;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            modeA_q <= MODE_RESET;
        end else if (wrModeA) begin
            modeA_q <= wrData;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            modeB_q <= MODE_RESET;
        end else if (wrModeB) begin
            modeB_q <= wrData;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flopA_q <= FLOP_RESET;
        end else if (wrFlopA) begin
            flopA_q <= flopStore(wrData);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flopB_q <= FLOP_RESET;
        end else if (wrFlopB) begin
            flopB_q <= flopStore(wrData);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irqMask_q <= IRQ_RESET;
        end else if (wrMask) begin
            irqMask_q <= wrData[IRQ_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Compare registers and buffers
    // ------------------------------------------------------------
    // Buffers keep the last write, but no mode, timer or waveform, ever loads the compare from them
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lBufA_q <= CMP_RESET;
            lCmpA_q <= CMP_RESET;
            uCmpA_q <= CMP_RESET;
        end else begin
            if (wrLCmpA) lBufA_q <= wrData;
            if (wrLCmpA && !runA_q[RUN_DBUF]) lCmpA_q <= wrData;
            if (wrUCmpA) uCmpA_q <= wrData;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lBufB_q <= CMP_RESET;
            lCmpB_q <= CMP_RESET;
            uCmpB_q <= CMP_RESET;
        end else begin
            if (wrLCmpB) lBufB_q <= wrData;
            if (wrLCmpB && !runB_q[RUN_DBUF]) lCmpB_q <= wrData;
            if (wrUCmpB) uCmpB_q <= wrData;
        end
    end

    // ------------------------------------------------------------
    // Prescalers and counters
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            preA_q <= '0;
            preB_q <= '0;
            preAPrev_q <= '0;
            preBPrev_q <= '0;
        end else begin
            preA_q <= nextPre(runA_q[RUN_PRESC], actA, preA_q);
            preB_q <= nextPre(runB_q[RUN_PRESC], actB, preB_q);
            preAPrev_q <= preA_q;
            preBPrev_q <= preB_q;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cntLA_q <= CNT_RESET;
            cntUA_q <= CNT_RESET;
            cntLB_q <= CNT_RESET;
            cntUB_q <= CNT_RESET;
        end else begin
            cntLA_q <= nextCount(runA_q[RUN_LOWER], matchLA, cntLA_q, tickLA);
            cntUA_q <= nextCount(runA_q[RUN_UPPER], matchUA, cntUA_q, tickUA);
            cntLB_q <= nextCount(runB_q[RUN_LOWER], matchLB, cntLB_q, tickLB);
            cntUB_q <= nextCount(runB_q[RUN_UPPER], matchUB, cntUB_q, tickUB);
        end
    end

    // ------------------------------------------------------------
    // Output flops and interrupts
    // ------------------------------------------------------------
    // Pin copies trail the flops by one clock so every output leaves a register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            outA_q <= 1'b0;
            flopOutputPinA <= 1'b0;
        end else begin
            outA_q <= nextOut(outA_q, wrFlopA, wrData[FLOP_CMD+1:FLOP_CMD], togA);
            flopOutputPinA <= outA_q;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            outB_q <= 1'b0;
            flopOutputPinB <= 1'b0;
        end else begin
            outB_q <= nextOut(outB_q, wrFlopB, wrData[FLOP_CMD+1:FLOP_CMD], togB);
            flopOutputPinB <= outB_q;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irqStat_q <= IRQ_RESET;
            irqOut <= 1'b0;
        end else begin
            irqStat_q <= irqStatD;
            irqOut <= |(irqStatD & irqMask_q);
        end
    end

endmodule : dit_timer_regs

/* File: verif/dit_timer_regs_chk.sv */
// Port-level checker for the dual interval timer register block
`timescale 1ns/1ps
module dit_timer_regs_chk
    import dit_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [10:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic externalCountPin,
    input wire logic secondIdleMode,
    input wire logic flopOutputPinA,
    input wire logic flopOutputPinB,
    input wire logic irqOut
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire logic [8:0] idx = wb_adr_i[10:2];
    wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic rdReq = wb_cyc_i && wb_stb_i && !wb_we_i;
    wire logic cmpIdx = idx == OFF_A_LCMP || idx == OFF_A_UCMP || idx == OFF_B_LCMP || idx == OFF_B_UCMP;
    sequence rdDone(logic [8:0] a);
        wb_ack_o && $past(rdReq) && $past(idx) == a;
    endsequence
    // Enable bit written low, though a match toggle in the command cycle still follows the stored enable bit
    sequence flopWr(logic [8:0] a, logic [1:0] c);
        req && wb_we_i && wb_sel_i[0] && idx == a && wb_dat_i[3:2] == c && !wb_dat_i[1];
    endsequence
    ack_after_req_a:
        assert property (req |=> wb_ack_o) else $error("ack missing after request");
    ack_one_cycle_a:
        assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    ack_has_req_a:
        assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    cmp_reads_zero_a:
        assert property (wb_ack_o && $past(rdReq && cmpIdx) |-> wb_dat_o == 32'h0) else $error("compare readable");
    run_gap_zero_a:
        assert property (rdDone(OFF_A_RUN) or rdDone(OFF_B_RUN) |-> wb_dat_o[31:4] == 28'h8 * wb_dat_o[7])
        else $error("run read gap bits not zero");
    flop_cmd_reads_a:
        assert property (rdDone(OFF_A_FLOP) or rdDone(OFF_B_FLOP) |-> wb_dat_o[3:2] == 2'h3)
        else $error("flop command field not read as keep");
    flop_set_a:
        assert property (flopWr(OFF_A_FLOP, CMD_SET) |=> ##1 flopOutputPinA) else $error("set command failed");
    flop_clear_a:
        assert property (flopWr(OFF_B_FLOP, CMD_CLEAR) |=> ##1 !flopOutputPinB) else $error("clear command failed");
    mask_quiet_a:
        assert property (req && wb_we_i && wb_sel_i[0] && idx == OFF_IRQ_MASK && wb_dat_i[3:0] == 4'h0
            |=> ##1 !irqOut [*3]) else $error("irq high with all masked");
endmodule : dit_timer_regs_chk

/* File: verif/tb.sv */
// Self-checking bench for the dual interval timer register block
`timescale 1ns/1ps
`define CHK(nm, e, g) \
    begin \
        num_checks++; \
        if ((g) !== (e)) begin \
            fails++; \
            $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
        end \
    end
module tb
    import dit_pkg::*;
;
    logic clk, rst, cyc, stb, we, ack, ext, idle, pinA, pinB, irq;
    logic [10:0] adr;
    logic [3:0] sel;
    logic [31:0] dat, dato;
    int fails, num_checks, dt;
    dit_timer_regs u_dit_timer_regs (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dato), .wb_ack_o(ack),
        .externalCountPin(ext), .secondIdleMode(idle), .flopOutputPinA(pinA), .flopOutputPinB(pinB),
        .irqOut(irq));
    // ----------------------------------------
    // Bus and measurement helpers
    // ----------------------------------------
    task automatic wbx(input logic w, input logic [8:0] i, input logic [7:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we} <= {2'b11, w};
        adr <= {i, 2'b00};
        dat <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        `CHK("ack", 1'b1, ack)
        q = dato;
        {cyc, stb, we} <= 3'b000;
    endtask : wbx
    task automatic wr(input logic [8:0] i, input logic [7:0] d);
        logic [31:0] q;
        wbx(1'b1, i, d, q);
    endtask : wr
    task automatic rdc(input string nm, input logic [8:0] i, input logic [31:0] e);
        logic [31:0] q;
        wbx(1'b0, i, 8'h00, q);
        `CHK(nm, e, q)
    endtask : rdc
    // Skips the partial interval, then times one full pin half-period
    task automatic per(input bit b, input int lim, output int t);
        logic v;
        int n;
        n = 0;
        v = b ? pinB : pinA;
        while ((b ? pinB : pinA) === v && n < lim) begin
            @(posedge clk);
            n++;
        end
        v = b ? pinB : pinA;
        t = 0;
        while ((b ? pinB : pinA) === v && t < lim) begin
            @(posedge clk);
            t++;
        end
    endtask : per
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        rdc("runA", OFF_A_RUN, 32'h0);
        rdc("modeA", OFF_A_MODE, 32'h0);
        rdc("flopA", OFF_A_FLOP, 32'h0C);
        rdc("runB", OFF_B_RUN, 32'h0);
        rdc("flopB", OFF_B_FLOP, 32'h0C);
        rdc("stat", OFF_IRQ_STAT, 32'h0);
    endtask : t_reset
    task automatic t_fields();
        wr(OFF_A_RUN, 8'hF8);
        rdc("runA", OFF_A_RUN, 32'h88);
        wr(OFF_A_RUN, 8'h00);
        for (int k = 0; k < 4; k++) begin
            wr(OFF_B_MODE, 8'(k << 6));
            rdc("modeB", OFF_B_MODE, 32'(k << 6));
        end
        wr(OFF_A_LCMP, 8'h5A);
        rdc("cmpA", OFF_A_LCMP, 32'h0);
        wr(9'h1F0, 8'hFF);
        rdc("unmapped", 9'h1F0, UNMAPPED_DATA);
    endtask : t_fields
    task automatic t_flop();
        logic [7:0] cmd [5] = '{8'h04, 8'h08, 8'h00, 8'h0C, 8'h00};
        logic res [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
        for (int k = 0; k < 5; k++) begin
            wr(OFF_A_FLOP, cmd[k]);
            repeat (2) @(posedge clk);
            `CHK("pinA", res[k], pinA)
        end
    endtask : t_flop
    task automatic t_ext();
        logic v;
        wr(OFF_A_MODE, 8'h00);
        wr(OFF_A_LCMP, 8'h02);
        wr(OFF_A_FLOP, 8'h0A);
        wr(OFF_A_RUN, 8'h05);
        v = pinA;
        repeat (2) begin
            ext <= 1'b1;
            repeat (4) @(posedge clk);
            ext <= 1'b0;
            repeat (4) @(posedge clk);
        end
        repeat (6) @(posedge clk);
        `CHK("extToggle", ~v, pinA)
    endtask : t_ext
    task automatic t_timer();
        int n;
        wr(OFF_A_LCMP, 8'h03);
        for (int k = 3; k > 0; k--) begin
            wr(OFF_A_MODE, 8'(k));
            per(1'b0, 3000, dt);
            `CHK("tapA", 12 << (2 * (k - 1)), dt)
        end
        wr(OFF_A_RUN, 8'h85);
        wr(OFF_A_LCMP, 8'h05);
        per(1'b0, 3000, dt);
        `CHK("dbufOn", 12, dt)
        wr(OFF_A_RUN, 8'h05);
        wr(OFF_A_LCMP, 8'h05);
        per(1'b0, 3000, dt);
        `CHK("dbufOff", 20, dt)
        wr(OFF_A_LCMP, 8'h00);
        per(1'b0, 3000, dt);
        `CHK("cmpZero", 1024, dt)
        wr(OFF_A_LCMP, 8'h03);
        wr(OFF_IRQ_MASK, 8'h01);
        wr(OFF_IRQ_STAT, 8'h0F);
        n = 0;
        while (irq !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        `CHK("irq", 1'b1, irq)
        rdc("stat", OFF_IRQ_STAT, 32'h1);
        wr(OFF_IRQ_MASK, 8'h00);
        repeat (2) @(posedge clk);
        `CHK("irqMasked", 1'b0, irq)
        wr(OFF_A_RUN, 8'h04);
        wr(OFF_IRQ_STAT, 8'h0F);
        repeat (40) @(posedge clk);
        rdc("statStopped", OFF_IRQ_STAT, 32'h0);
    endtask : t_timer
    task automatic t_gate();
        wr(OFF_A_RUN, 8'h05);
        wr(OFF_A_FLOP, 8'h08);
        per(1'b0, 100, dt);
        `CHK("toggleOff", 100, dt)
        wr(OFF_A_FLOP, 8'h0B);
        per(1'b0, 100, dt);
        `CHK("srcUpper", 100, dt)
        wr(OFF_A_FLOP, 8'h0A);
        idle <= 1'b1;
        per(1'b0, 100, dt);
        `CHK("idleStop", 100, dt)
        wr(OFF_A_RUN, 8'h0D);
        per(1'b0, 3000, dt);
        `CHK("idleRun", 12, dt)
        idle <= 1'b0;
        wr(OFF_A_UCMP, 8'h02);
        wr(OFF_A_FLOP, 8'h0B);
        wr(OFF_A_RUN, 8'h07);
        per(1'b0, 3000, dt);
        `CHK("cascade", 24, dt)
        wr(OFF_A_RUN, 8'h00);
    endtask : t_gate
    task automatic t_pairb();
        wr(OFF_B_FLOP, 8'h08);
        wr(OFF_B_MODE, 8'hC0);
        wr(OFF_B_LCMP, 8'h02);
        wr(OFF_IRQ_STAT, 8'h0F);
        wr(OFF_B_RUN, 8'h05);
        repeat (60) @(posedge clk);
        rdc("lowerB", OFF_IRQ_STAT, 32'h0);
        wr(OFF_B_UCMP, 8'h02);
        wr(OFF_B_FLOP, 8'h0B);
        wr(OFF_B_RUN, 8'h06);
        for (int k = 1; k < 4; k++) begin
            wr(OFF_B_MODE, 8'(k << 2));
            per(1'b1, 3000, dt);
            `CHK("upperB", 8 << (4 * (k - 1)), dt)
        end
    endtask : t_pairb
    task automatic end_sim();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Longest scenario needs a few thousand cycles; generous margin
    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        end_sim();
    end
    initial begin
        {rst, cyc, stb, we, ext, idle} = 6'b100000;
        {adr, sel, dat} = {11'h0, 4'hF, 32'h0};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_fields();
        t_flop();
        t_ext();
        t_timer();
        t_gate();
        t_pairb();
        end_sim();
    end
endmodule : tb
bind dit_timer_regs dit_timer_regs_chk u_dit_timer_regs_chk (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .externalCountPin(externalCountPin),
    .secondIdleMode(secondIdleMode), .flopOutputPinA(flopOutputPinA), .flopOutputPinB(flopOutputPinB),
    .irqOut(irqOut));
